/* rtl/exec_consts.svh */
// constants for the stack, return, negate and rotate execution unit
`ifndef EXEC_CONSTS_SVH
`define EXEC_CONSTS_SVH

// -----------------------------------------------------------------------------
// register byte offsets (low eight address bits)
// -----------------------------------------------------------------------------
`define OFF_CTRL        8'h00
`define OFF_INSTR       8'h04
`define OFF_RUN         8'h08
`define OFF_WORK        8'h0C
`define OFF_FLAGS       8'h10
`define OFF_BANK        8'h14
`define OFF_PC          8'h18
`define OFF_TOP         8'h1C
`define OFF_SHADOW      8'h20
`define OFF_INDEX       8'h24
`define OFF_DADDR       8'h28
`define OFF_DDATA       8'h2C
`define OFF_LATCH       8'h30

// -----------------------------------------------------------------------------
// field positions
// -----------------------------------------------------------------------------
`define CTRL_EXT_BIT    0
`define CTRL_HIGH_BIT   1
`define CTRL_LOW_BIT    2
`define RUN_OVF_BIT     1
`define RUN_UNF_BIT     2
`define FLAG_C          0
`define FLAG_DC         1
`define FLAG_Z          2
`define FLAG_OV         3
`define FLAG_N          4
`define MASK_ARITH      5'h1F
`define MASK_ROT_C      5'h15
`define MASK_ROT_NC     5'h14

// -----------------------------------------------------------------------------
// opcode matches
// -----------------------------------------------------------------------------
`define OPC_NEGATE      7'h36
`define OPC_DROP        16'h0006
`define OPC_PUSH        16'h0005
`define OPC_REL_CALL    5'h1B
`define OPC_SOFT_RESET  16'h00FF
`define OPC_INT_RET     15'h0008
`define OPC_SUB_RET     15'h0009
`define OPC_RET_LIT     8'h0C
`define OPC_ROT_LC      6'h0D
`define OPC_ROT_LNC     6'h11
`define OPC_ROT_RC      6'h0C

// -----------------------------------------------------------------------------
// addressing, stack, timing and reset values
// -----------------------------------------------------------------------------
`define ACCESS_LIMIT    8'h5F
`define ACCESS_HI_BANK  4'hF
`define STACK_LEVELS    31
`define STACK_FULL      5'h1F
`define LAST_QUARTER    2'h3
`define PC_STEP         21'h000002
`define RST_CTRL_BIT    1'h0
`define RST_BYTE        8'h00
`define RST_FLAGS       5'h00
`define RST_BANK        4'h0
`define RST_PC          21'h000000
`define RST_UPPER       5'h00
`define RST_INDEX       12'h000

`endif

/* rtl/exec_pkg.sv */
// types shared by the execution unit and its helpers
package exec_pkg;

  typedef logic [20:0] pc_t;
  typedef logic [4:0]  flags_t;

  typedef enum logic [2:0] {
    ALU_PASS,
    ALU_NEGATE,
    ALU_ROT_LEFT_C,
    ALU_ROT_LEFT_NC,
    ALU_ROT_RIGHT_C
  } alu_op_t;

  typedef enum logic [3:0] {
    OP_NONE,
    OP_NEGATE_FILE,
    OP_DROP,
    OP_PUSH,
    OP_REL_CALL,
    OP_SOFT_RESET,
    OP_INT_RETURN,
    OP_SUB_RETURN,
    OP_RET_LITERAL,
    OP_ROT_LEFT_C,
    OP_ROT_LEFT_NC,
    OP_ROT_RIGHT_C
  } op_class_t;

  typedef enum logic [2:0] {
    S_IDLE,
    S_DECODE,
    S_READ,
    S_PROCESS,
    S_WRITE,
    S_SECOND
  } exec_state_t;

endpackage

/* rtl/rotate_negate_alu.sv */
// byte negate and rotate datapath with flag results
`timescale 1ns/100ps
`include "exec_consts.svh"
module rotate_negate_alu
  import exec_pkg::*;
(
  input  alu_op_t     op,        // operation select
  input  logic [7:0]  operand,   // file byte read in the second quarter
  input  logic        carry_in,  // current carry flag
  output logic [7:0]  result,    // processed byte
  output flags_t      flags,     // new flag values
  output flags_t      mask       // which flags the operation writes
);

  always_comb begin
    logic [8:0] sum9;
    logic [4:0] sum5;
    sum9   = {1'b0, ~operand} + 9'h001;
    sum5   = {1'b0, ~operand[3:0]} + 5'h01;
    result = operand;
    flags  = '0;
    mask   = '0;
    unique case (op)
      ALU_NEGATE: begin
        result             = sum9[7:0];
        flags[`FLAG_C]     = sum9[8];
        flags[`FLAG_DC]    = sum5[4];
        flags[`FLAG_OV]    = (operand == 8'h80);
        mask               = `MASK_ARITH;
      end
      ALU_ROT_LEFT_C: begin
        result             = {operand[6:0], carry_in};
        flags[`FLAG_C]     = operand[7];
        mask               = `MASK_ROT_C;
      end
      ALU_ROT_LEFT_NC: begin
        result             = {operand[6:0], operand[7]};
        mask               = `MASK_ROT_NC;
      end
      ALU_ROT_RIGHT_C: begin
        result             = {carry_in, operand[7:1]};
        flags[`FLAG_C]     = operand[0];
        mask               = `MASK_ROT_C;
      end
      ALU_PASS: begin
      end
    endcase
    flags[`FLAG_Z] = (result == 8'h00);
    flags[`FLAG_N] = result[7];
  end

endmodule

/* rtl/return_stack.sv */
// hardware return stack of 31 program counter entries
`timescale 1ns/100ps
`include "exec_consts.svh"
module return_stack
  import exec_pkg::*;
(
  input  wire logic        hclk,        // core clock
  input  wire logic        hresetn,     // asynchronous reset, active low
  input  wire logic        clear,       // empty the stack
  input  wire logic        push,        // push push_value
  input  wire logic        pop,         // discard the top entry
  input  pc_t              push_value,  // value pushed
  output pc_t              top,         // current top entry
  output logic [4:0]       depth        // entries in use
);

  typedef struct packed {
    logic [4:0] ptr;
  } stk_t;

  stk_t r, n;
  pc_t  slot [0:`STACK_LEVELS-1];

  always_comb begin
    n = r;
    if (clear) begin
      n.ptr = 5'h00;
    end else if (push && r.ptr != `STACK_FULL) begin
      n.ptr = r.ptr + 5'h01;
    end else if (pop && r.ptr != 5'h00) begin
      n.ptr = r.ptr - 5'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // a push onto a full stack is dropped, the owner flags it
  always_ff @(posedge hclk) begin
    if (!clear && push && r.ptr != `STACK_FULL) begin
      slot[r.ptr] <= push_value;
    end
  end

  assign top   = (r.ptr == 5'h00) ? `RST_PC : slot[r.ptr - 5'h01];
  assign depth = r.ptr;

endmodule

/* rtl/stack_return_rotate_ops.sv */
// execution unit for negate, return-stack, return and rotate instructions
`timescale 1ns/100ps
`include "exec_consts.svh"
// -----------------------------------------------------------------------------
// Summary of operation
// - negate file byte, write back, update five flags
// - access bit 0 access bank, 1 uses bank
// - access, extended set, address <= 95: indexed offset
// - drop discards top, one cycle
// - push stores pc plus 2 as top
// - relative call pushes pc plus 2 first
// - relative call jumps by twice offset, two cycles
// - software reset restores registers, data address, fault bits and stack, not instr
// - interrupt return pops pc, sets one enable
// - restore bit copies shadow registers back
// - literal return loads work, pops pc
// - literal return leaves pc latches untouched
// - subroutine return pops pc, latches kept, two cycles
// - rotate left through carry, flags C N Z
// - rotate right through carry, d selects target
// -----------------------------------------------------------------------------
module stack_return_rotate_ops
  import exec_pkg::*;
(
  input  wire logic        hclk,       // core clock, one quarter per edge
  input  wire logic        hresetn,    // asynchronous reset, active low
  input  wire logic        hsel,       // slave select
  input  wire logic [31:0] haddr,      // byte address
  input  wire logic [1:0]  htrans,     // transfer type
  input  wire logic        hwrite,     // write when high
  input  wire logic [2:0]  hsize,      // only words are used
  input  wire logic [31:0] hwdata,     // write data
  input  wire logic        hready,     // bus ready
  output logic [31:0]      hrdata,     // read data
  output logic             hreadyout,  // slave ready
  output logic             hresp,      // always okay
  output logic             exec_busy   // instruction in flight
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic       ext_en;
    logic       high_prio_int_enable;
    logic       low_prio_int_enable;
    logic [7:0] wreg;
    flags_t     flags;
    logic [3:0] bank_select_register;
    pc_t        pc;
    logic [7:0] shadow_work_copy;
    flags_t     shadow_flags_copy;
    logic [3:0] shadow_bank_copy;
    logic [7:0] pc_high_latch;
    logic [4:0] pc_upper_latch;
    logic [11:0] index_base;
  } arch_t;

  typedef struct packed {
    arch_t       a;
    exec_state_t st;
    logic [1:0]  quarter;
    op_class_t   cls;
    logic [15:0] instr;
    logic [11:0] faddr;
    logic [7:0]  opnd;
    logic [7:0]  res;
    flags_t      res_flags;
    flags_t      res_mask;
    logic [11:0] data_addr;
    logic        overflow_seen;
    logic        underflow_seen;
    logic        ap_wr;
    logic        rd_wait;
    logic [7:0]  ap_addr;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        resp;
    logic        busy;
  } core_t;

  localparam arch_t ARCH_RESET = '{
    ext_en:               `RST_CTRL_BIT,
    high_prio_int_enable: `RST_CTRL_BIT,
    low_prio_int_enable:  `RST_CTRL_BIT,
    wreg:                 `RST_BYTE,
    flags:                `RST_FLAGS,
    bank_select_register: `RST_BANK,
    pc:                   `RST_PC,
    shadow_work_copy:     `RST_BYTE,
    shadow_flags_copy:    `RST_FLAGS,
    shadow_bank_copy:     `RST_BANK,
    pc_high_latch:        `RST_BYTE,
    pc_upper_latch:       `RST_UPPER,
    index_base:           `RST_INDEX
  };

  core_t       r, n;
  logic [7:0]  data_mem [0:4095];
  logic        dm_we;
  logic [11:0] dm_wa;
  logic [7:0]  dm_wd;
  logic        stk_push;
  logic        stk_pop;
  logic        stk_clear;
  pc_t         stk_val;
  pc_t         stk_top;
  logic [4:0]  stk_depth;
  alu_op_t     alu_op;
  logic [7:0]  alu_res;
  flags_t      alu_flags;
  flags_t      alu_mask;
  logic [31:0] rd_value;
  pc_t         pc_next;
  pc_t         call_target;

  // ---------------------------------------------------------------------------
  // decode and addressing helpers
  // ---------------------------------------------------------------------------
  function automatic op_class_t decode(input logic [15:0] i);
    op_class_t c;
    c = OP_NONE;
    if (i[15:9] == `OPC_NEGATE) begin
      c = OP_NEGATE_FILE;
    end else if (i == `OPC_DROP) begin
      c = OP_DROP;
    end else if (i == `OPC_PUSH) begin
      c = OP_PUSH;
    end else if (i[15:11] == `OPC_REL_CALL) begin
      c = OP_REL_CALL;
    end else if (i == `OPC_SOFT_RESET) begin
      c = OP_SOFT_RESET;
    end else if (i[15:1] == `OPC_INT_RET) begin
      c = OP_INT_RETURN;
    end else if (i[15:1] == `OPC_SUB_RET) begin
      c = OP_SUB_RETURN;
    end else if (i[15:8] == `OPC_RET_LIT) begin
      c = OP_RET_LITERAL;
    end else if (i[15:10] == `OPC_ROT_LC) begin
      c = OP_ROT_LEFT_C;
    end else if (i[15:10] == `OPC_ROT_LNC) begin
      c = OP_ROT_LEFT_NC;
    end else if (i[15:10] == `OPC_ROT_RC) begin
      c = OP_ROT_RIGHT_C;
    end
    return c;
  endfunction

  function automatic logic [11:0] file_addr(input logic [15:0] i, input arch_t a);
    logic [11:0] fa;
    fa = {a.bank_select_register, i[7:0]};
    if (!i[8]) begin
      if (a.ext_en && i[7:0] <= `ACCESS_LIMIT) begin
        fa = a.index_base + {4'h0, i[7:0]};
      end else if (i[7:0] <= `ACCESS_LIMIT) begin
        fa = {`RST_BANK, i[7:0]};
      end else begin
        fa = {`ACCESS_HI_BANK, i[7:0]};
      end
    end
    return fa;
  endfunction

  always_comb begin
    unique case (r.cls)
      OP_NEGATE_FILE: alu_op = ALU_NEGATE;
      OP_ROT_LEFT_C:  alu_op = ALU_ROT_LEFT_C;
      OP_ROT_LEFT_NC: alu_op = ALU_ROT_LEFT_NC;
      OP_ROT_RIGHT_C: alu_op = ALU_ROT_RIGHT_C;
      default:        alu_op = ALU_PASS;
    endcase
  end

  assign pc_next     = r.a.pc + `PC_STEP;
  assign call_target = pc_next + {{9{r.instr[10]}}, r.instr[10:0], 1'b0};

  // ---------------------------------------------------------------------------
  // read mux; fields above a register's width read as zero
  // ---------------------------------------------------------------------------
  always_comb begin
    rd_value = 32'h00000000;
    unique case (r.ap_addr)
      `OFF_CTRL:   rd_value = {29'h0, r.a.low_prio_int_enable,
                               r.a.high_prio_int_enable, r.a.ext_en};
      `OFF_INSTR:  rd_value = {16'h0, r.instr};
      `OFF_RUN:    rd_value = {19'h0, stk_depth, 5'h0, r.underflow_seen,
                               r.overflow_seen, r.busy};
      `OFF_WORK:   rd_value = {24'h0, r.a.wreg};
      `OFF_FLAGS:  rd_value = {27'h0, r.a.flags};
      `OFF_BANK:   rd_value = {28'h0, r.a.bank_select_register};
      `OFF_PC:     rd_value = {11'h0, r.a.pc};
      `OFF_TOP:    rd_value = {11'h0, stk_top};
      `OFF_SHADOW: rd_value = {12'h0, r.a.shadow_bank_copy, 3'h0,
                               r.a.shadow_flags_copy, r.a.shadow_work_copy};
      `OFF_INDEX:  rd_value = {20'h0, r.a.index_base};
      `OFF_DADDR:  rd_value = {20'h0, r.data_addr};
      `OFF_DDATA:  rd_value = {24'h0, data_mem[r.data_addr]};
      `OFF_LATCH:  rd_value = {19'h0, r.a.pc_upper_latch, r.a.pc_high_latch};
      default:     rd_value = 32'h00000000;
    endcase
  end

  // ---------------------------------------------------------------------------
  // next state: bus slave, then the quarter-cycle sequencer
  // ---------------------------------------------------------------------------
  always_comb begin
    n         = r;
    dm_we     = 1'b0;
    dm_wa     = r.faddr;
    dm_wd     = r.res;
    stk_push  = 1'b0;
    stk_pop   = 1'b0;
    stk_clear = 1'b0;
    stk_val   = pc_next;

    // write data phase; dropped while an instruction runs so the two never race
    if (r.ap_wr) begin
      n.ap_wr = 1'b0;
      if (r.st == S_IDLE) begin
        unique case (r.ap_addr)
          `OFF_CTRL: begin
            n.a.ext_en               = hwdata[`CTRL_EXT_BIT];
            n.a.high_prio_int_enable = hwdata[`CTRL_HIGH_BIT];
            n.a.low_prio_int_enable  = hwdata[`CTRL_LOW_BIT];
          end
          `OFF_INSTR: begin
            n.instr = hwdata[15:0];
            n.st    = S_DECODE;
          end
          `OFF_RUN: begin
            n.overflow_seen  = r.overflow_seen & ~hwdata[`RUN_OVF_BIT];
            n.underflow_seen = r.underflow_seen & ~hwdata[`RUN_UNF_BIT];
          end
          `OFF_WORK:   n.a.wreg                 = hwdata[7:0];
          `OFF_FLAGS:  n.a.flags                = hwdata[4:0];
          `OFF_BANK:   n.a.bank_select_register = hwdata[3:0];
          `OFF_PC:     n.a.pc                   = {hwdata[20:1], 1'b0};
          `OFF_SHADOW: begin
            n.a.shadow_work_copy  = hwdata[7:0];
            n.a.shadow_flags_copy = hwdata[12:8];
            n.a.shadow_bank_copy  = hwdata[19:16];
          end
          `OFF_INDEX:  n.a.index_base = hwdata[11:0];
          `OFF_DADDR:  n.data_addr    = hwdata[11:0];
          `OFF_DDATA: begin
            dm_we = 1'b1;
            dm_wa = r.data_addr;
            dm_wd = hwdata[7:0];
          end
          `OFF_LATCH: begin
            n.a.pc_high_latch  = hwdata[7:0];
            n.a.pc_upper_latch = hwdata[12:8];
          end
          default: begin
          end
        endcase
      end
    end

    // read answer one cycle late, so a write just before is already visible
    if (r.rd_wait) begin
      n.hrdata    = rd_value;
      n.hreadyout = 1'b1;
      n.rd_wait   = 1'b0;
    end

    if (hsel && hready && htrans[1]) begin
      n.ap_addr = haddr[7:0];
      if (hwrite) begin
        n.ap_wr = 1'b1;
      end else begin
        n.rd_wait   = 1'b1;
        n.hreadyout = 1'b0;
      end
    end

    unique case (r.st)
      S_IDLE: begin
      end
      S_DECODE: begin
        n.cls   = decode(r.instr);
        n.faddr = file_addr(r.instr, r.a);
        n.st    = S_READ;
      end
      S_READ: begin
        n.opnd = data_mem[r.faddr];
        n.st   = S_PROCESS;
      end
      S_PROCESS: begin
        n.res       = alu_res;
        n.res_flags = alu_flags;
        n.res_mask  = alu_mask;
        n.st        = S_WRITE;
      end
      S_WRITE: begin
        n.st   = S_IDLE;
        n.a.pc = pc_next;
        unique case (r.cls)
          OP_NEGATE_FILE: begin
            dm_we = 1'b1;
          end
          OP_ROT_LEFT_C, OP_ROT_LEFT_NC, OP_ROT_RIGHT_C: begin
            if (r.instr[9]) begin
              dm_we = 1'b1;
            end else begin
              n.a.wreg = r.res;
            end
          end
          OP_DROP: begin
            stk_pop = 1'b1;
          end
          OP_PUSH: begin
            stk_push = 1'b1;
          end
          OP_REL_CALL: begin
            stk_push = 1'b1;
            n.a.pc   = call_target;
            n.st     = S_SECOND;
          end
          OP_SOFT_RESET: begin
            n.a              = ARCH_RESET;
            n.data_addr      = `RST_INDEX;
            n.overflow_seen  = 1'b0;
            n.underflow_seen = 1'b0;
            stk_clear        = 1'b1;
          end
          OP_INT_RETURN, OP_SUB_RETURN, OP_RET_LITERAL: begin
            stk_pop = 1'b1;
            n.a.pc  = stk_top;
            n.st    = S_SECOND;
            // latches are left alone on every return form
            n.a.pc_high_latch  = r.a.pc_high_latch;
            n.a.pc_upper_latch = r.a.pc_upper_latch;
            if (r.cls == OP_RET_LITERAL) begin
              n.a.wreg = r.instr[7:0];
            end else if (r.instr[0]) begin
              n.a.wreg                 = r.a.shadow_work_copy;
              n.a.flags                = r.a.shadow_flags_copy;
              n.a.bank_select_register = r.a.shadow_bank_copy;
            end
            if (r.cls == OP_INT_RETURN) begin
              // the higher level returns first, so re-enable it first
              if (!r.a.high_prio_int_enable) begin
                n.a.high_prio_int_enable = 1'b1;
              end else begin
                n.a.low_prio_int_enable = 1'b1;
              end
            end
          end
          default: begin
          end
        endcase
        if (r.cls != OP_SOFT_RESET) begin
          n.a.flags = (n.a.flags & ~r.res_mask) | (r.res_flags & r.res_mask);
        end
        n.quarter = 2'h0;
      end
      S_SECOND: begin
        n.quarter = r.quarter + 2'h1;
        if (r.quarter == `LAST_QUARTER) begin
          n.st = S_IDLE;
        end
      end
    endcase

    // stack faults are sticky; set wins over a clear in the same cycle
    if (stk_push && stk_depth == `STACK_FULL) begin
      n.overflow_seen = 1'b1;
    end
    if (stk_pop && stk_depth == 5'h00) begin
      n.underflow_seen = 1'b1;
    end
    n.busy = (n.st != S_IDLE);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r           <= '0;
      r.a         <= ARCH_RESET;
      r.st        <= S_IDLE;
      r.cls       <= OP_NONE;
      r.hreadyout <= 1'b1;
    end else begin
      r <= n;
    end
  end

  always_ff @(posedge hclk) begin
    if (dm_we) begin
      data_mem[dm_wa] <= dm_wd;
    end
  end

  // ---------------------------------------------------------------------------
  // datapath and stack
  // ---------------------------------------------------------------------------
  rotate_negate_alu u_alu (
    .op       (alu_op),
    .operand  (r.opnd),
    .carry_in (r.a.flags[`FLAG_C]),
    .result   (alu_res),
    .flags    (alu_flags),
    .mask     (alu_mask)
  );

  return_stack u_stack (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .clear      (stk_clear),
    .push       (stk_push),
    .pop        (stk_pop),
    .push_value (stk_val),
    .top        (stk_top),
    .depth      (stk_depth)
  );

  assign hrdata    = r.hrdata;
  assign hreadyout = r.hreadyout;
  assign hresp     = r.resp;
  assign exec_busy = r.busy;

endmodule

/* dv/exec_checker_assertions.sv */
// bus and execution timing checker for the execution unit
`timescale 1ns/100ps
module exec_checker (
  input wire logic        hclk,      // clock
  input wire logic        hresetn,   // reset
  input wire logic        hsel,      // select
  input wire logic [31:0] haddr,     // address
  input wire logic [1:0]  htrans,    // type
  input wire logic        hwrite,    // write
  input wire logic [31:0] hwdata,    // write data
  input wire logic        hready,    // ready in
  input wire logic [31:0] hrdata,    // read data
  input wire logic        hreadyout, // ready out
  input wire logic        hresp,     // response
  input wire logic        exec_busy  // busy
);
  logic        take, pend_r, one_cyc, two_cyc;
  logic [15:0] op_r;
  assign take = hsel && hready && htrans[1];
  assign one_cyc = op_r == 16'h0005 || op_r == 16'h0006 || op_r[15:9] == 7'h36;
  assign two_cyc = op_r[15:11] == 5'h1B || op_r[15:2] == 14'h0004 || op_r[15:8] == 8'h0C;
  // opcode seen at the data edge that starts execution
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_r <= 1'b0;
      op_r <= 16'h0000;
    end else begin
      pend_r <= take && hwrite && haddr[7:0] == 8'h04;
      if (pend_r) begin
        op_r <= hwdata[15:0];
      end
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  resp_okay_a: assert property (!hresp)
    else $error("response not okay");
  read_wait_a: assert property (take && !hwrite |=> !hreadyout)
    else $error("read without wait");
  wait_once_a: assert property (!hreadyout |=> hreadyout)
    else $error("wait too long");
  rdata_hold_a: assert property ($changed(hrdata) |-> $rose(hreadyout))
    else $error("read data moved");
  instr_start_a: assert property (take && hwrite && haddr[7:0] == 8'h04 && !exec_busy
    |-> ##2 exec_busy) else $error("execution not started");
  single_len_a: assert property ($rose(exec_busy) && one_cyc
    |-> exec_busy[*4] ##1 !exec_busy) else $error("single cycle length wrong");
  double_len_a: assert property ($rose(exec_busy) && two_cyc
    |-> exec_busy[*8] ##1 !exec_busy) else $error("two cycle length wrong");
  busy_bound_a: assert property ($rose(exec_busy) |-> ##[4:9] !exec_busy)
    else $error("busy too long");
endmodule

/* dv/testbench.sv */
// self-checking bench for the execution unit
`timescale 1ns/100ps
module testbench;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic [1:0]  htrans = 2'h0;
  logic        hreadyout, hresp, exec_busy;
  int          fails = 0, compares = 0, cyc = 0;
  always #12.5 hclk = ~hclk;
  stack_return_rotate_ops DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .exec_busy(exec_busy));
  // ---------------------------------------------------------------------------
  // bus tasks
  // ---------------------------------------------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    compares++;
    if (r !== e) begin
      fails++;
      $display("CHECK FAILED %0t addr %h got %h exp %h", $time, a, r, e);
    end
  endtask
  // writes are dropped while busy, so always wait it out
  task automatic run(input logic [15:0] op);
    wr(8'h04, {16'h0, op});
    do @(posedge hclk); while (exec_busy === 1'b1);
  endtask
  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic reset_test;
    chk(8'h18, 32'h0);
    chk(8'hFC, 32'h0);
  endtask
  task automatic neg_case(input logic [2:0] ctl, input logic [15:0] op, input logic [11:0] da,
      input logic [7:0] v, e, input logic [4:0] ef);
    wr(8'h00, {29'h0, ctl});
    wr(8'h28, {20'h0, da});
    wr(8'h2C, {24'h0, v});
    run(op);
    chk(8'h2C, {24'h0, e});
    chk(8'h10, {27'h0, ef});
  endtask
  task automatic rot_case(input logic [15:0] op, input logic [4:0] fl,
      input logic [7:0] v, e, ew, input logic [4:0] ef);
    wr(8'h10, {27'h0, fl});
    wr(8'h0C, 32'h55);
    wr(8'h28, 32'h320);
    wr(8'h2C, {24'h0, v});
    run(op);
    chk(8'h2C, {24'h0, e});
    chk(8'h0C, {24'h0, ew});
    chk(8'h10, {27'h0, ef});
  endtask
  task automatic stack_test;
    wr(8'h18, 32'h100);
    wr(8'h30, 32'h1A5B);
    run(16'h0005);
    chk(8'h1C, 32'h102);
    chk(8'h08, 32'h100);
    run(16'h0005);
    run(16'h0006);
    chk(8'h1C, 32'h102);
    run(16'hDFFE);
    chk(8'h1C, 32'h108);
    chk(8'h18, 32'h104);
    wr(8'h20, 32'h7155A);
    run(16'h0013);
    chk(8'h18, 32'h108);
    chk(8'h0C, 32'h5A);
    chk(8'h10, 32'h15);
    chk(8'h14, 32'h7);
    wr(8'h20, 32'h0);
    run(16'h0010);
    chk(8'h18, 32'h102);
    chk(8'h00, 32'h3);
    chk(8'h0C, 32'h5A);
    run(16'h0005);
    run(16'h0C9C);
    chk(8'h0C, 32'h9C);
    chk(8'h18, 32'h104);
    chk(8'h30, 32'h1A5B);
    // leave one entry on the stack so the reset has something to clear
    run(16'h0005);
    run(16'h00FF);
    chk(8'h18, 32'h0);
    chk(8'h00, 32'h0);
    chk(8'h0C, 32'h0);
    chk(8'h08, 32'h0);
    run(16'h0006);
    chk(8'h08, 32'h4);
    wr(8'h08, 32'h4);
    chk(8'h08, 32'h0);
  endtask
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    reset_test;
    wr(8'h14, 32'h3);
    wr(8'h24, 32'h100);
    neg_case(3'h0, 16'h6D45, 12'h345, 8'h3A, 8'hC6, 5'h10);
    neg_case(3'h0, 16'h6C60, 12'hF60, 8'h00, 8'h00, 5'h07);
    neg_case(3'h1, 16'h6C10, 12'h110, 8'h80, 8'h80, 5'h1A);
    rot_case(16'h3720, 5'h00, 8'hE6, 8'hCC, 8'h55, 5'h11);
    rot_case(16'h4720, 5'h03, 8'hAB, 8'h57, 8'h55, 5'h03);
    rot_case(16'h3120, 5'h14, 8'hE6, 8'hE6, 8'h73, 5'h00);
    stack_test;
    print_verdict;
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      print_verdict;
    end
  end
  task automatic print_verdict;
    if (fails == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
endmodule
bind stack_return_rotate_ops exec_checker chk_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .exec_busy(exec_busy));
